// *** otc_osc_tune.sv ***
// Internal oscillator tuning and PLL control with an AXI4-Lite slave.
// Assumes an AXI4-Lite master on aclk that keeps valid and payload stable
// until the handshake; only byte lane 0 carries register data.
//
// Contract
// - Centre trim gives nominal 8 MHz fast oscillator.
// - Slow RC settles within eight RC cycles.
// - Fast oscillator settles within one millisecond.
// - Writes never stall; no settle-done indication.
// - Every trim step changes frequency equally.
// - PLL multiplies by four, at most 32 MHz at centre trim.
// - Tuning bit 6 enables the PLL where mode and select allow it.
// - PLL allowed only in internal oscillator modes.
// - PLL runs only at 8 or 4 MHz.
// - Unavailable PLL enable held and read zero.
// - Bit 7 picks fast/256 or slow RC.
// - Trim field is signed around the centre.
// - Tuning bit 5 always reads zero.
// - Three-bit select: 7 direct, down to 0.
// - Watchdog always uses slow RC.
`timescale 1ns/10ps
module otc_osc_tune #(
  parameter int unsigned FAST_CYC  = otc_pkg::FAST_SETTLE_CYC, // Fast wait.
  parameter int unsigned SLOW_CYC  = otc_pkg::SLOW_SETTLE_CYC, // Slow wait.
  parameter int          STEP_KHZ  = 40   // Frequency change per trim step.
) (
  input  wire logic                     aclk,          // Clock, 250 MHz.
  input  wire logic                     aresetn,       // Reset, active low.
  input  wire logic [otc_pkg::ADDR_W-1:0] awaddr,      // Write address.
  input  wire logic                     awvalid,       // Write addr valid.
  output logic                          awready,       // Write addr ready.
  input  wire logic [31:0]              wdata,         // Write data.
  input  wire logic [3:0]               wstrb,         // Byte enables.
  input  wire logic                     wvalid,        // Write data valid.
  output logic                          wready,        // Write data ready.
  output logic [1:0]                    bresp,         // Write response.
  output logic                          bvalid,        // Response valid.
  input  wire logic                     bready,        // Response ready.
  input  wire logic [otc_pkg::ADDR_W-1:0] araddr,      // Read address.
  input  wire logic                     arvalid,       // Read addr valid.
  output logic                          arready,       // Read addr ready.
  output logic [31:0]                   rdata,         // Read data.
  output logic [1:0]                    rresp,         // Read response.
  output logic                          rvalid,        // Read data valid.
  input  wire logic                     rready,        // Read data ready.
  output logic [otc_pkg::TRIM_W-1:0]    fast_trim,     // Fast osc trim.
  output logic [otc_pkg::TRIM_W-1:0]    slow_trim,     // Slow RC trim.
  output logic                          pll_run,       // PLL engaged.
  output logic                          lf_from_fast,  // Low-freq source.
  output logic                          wdt_on_slow    // Watchdog source.
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic                        awready_q, wready_q, bvalid_q;  // Write side.
  logic                        arready_q, rvalid_q;            // Read side.
  logic [1:0]                  bresp_q, rresp_q;  // Responses.
  logic [31:0]                 rdata_q;           // Read data.
  logic                        aw_have_q;         // Address held.
  logic                        w_have_q;          // Data held.
  logic [otc_pkg::ADDR_W-1:0]  aw_addr_q;         // Held write address.
  logic [7:0]                  w_byte_q;          // Held lane 0 data.
  logic                        w_lane_q;          // Lane 0 enabled.
  logic                        lf_src_q;          // Low-freq source select.
  logic                        pll_en_q;          // PLL software enable.
  logic [otc_pkg::TRIM_W-1:0]  tune_q;            // Written trim field.
  logic [3:0]                  osc_cfg_q;         // Primary osc config.
  logic [2:0]                  fsel_q;            // Internal freq select.
  logic                        start_q;           // Trim update pulse.
  logic                        pll_q, lf_q, wdt_q; // Registered outputs.

  logic wr_fire;    // Both halves of a write are held.
  logic wr_hit;     // Write address is mapped.
  logic pll_avail;  // Oscillator configuration allows the PLL.
  logic freq_ok;    // Selected frequency allows the PLL.
  logic [15:0] fast_khz, dev_khz, base_khz;  // Frequency estimates.
  logic [31:0] rd_word;  // Read mux.
  logic        rd_hit;   // Read address is mapped.

  otc_trim_if fast_if ();
  otc_trim_if slow_if ();

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_hit  = aw_addr_q == otc_pkg::ADDR_TRIM
                || aw_addr_q == otc_pkg::ADDR_CFG
                || aw_addr_q == otc_pkg::ADDR_STAT
                || aw_addr_q == otc_pkg::ADDR_FREQ;

  // Address and data are taken independently, one of each per write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end else begin
      awready_q <= awvalid && !awready_q && !aw_have_q && !bvalid_q;
      wready_q  <= wvalid && !wready_q && !w_have_q && !bvalid_q;
    end
  end

  // Hold each half until the write is carried out.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_byte_q  <= 8'h00;
      w_lane_q  <= 1'b0;
    end else begin
      if (awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        w_have_q <= 1'b1;
        w_byte_q <= wdata[7:0];
        w_lane_q <= wstrb[0];
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Response follows one cycle after both halves; no wait on the clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= otc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? otc_pkg::RESP_OKAY : otc_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Tuning and configuration registers
  // ****************************************************************
  assign pll_avail = osc_cfg_q == otc_pkg::OSC_INT_IO2
                  || osc_cfg_q == otc_pkg::OSC_INT_IO1;
  assign freq_ok   = fsel_q == otc_pkg::FSEL_8M
                  || fsel_q == otc_pkg::FSEL_4M;

  // Trim and source select; a trim write also restarts both settle timers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_src_q <= 1'b0;
      tune_q   <= otc_pkg::TRIM_RST;
      start_q  <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (wr_fire && w_lane_q && aw_addr_q == otc_pkg::ADDR_TRIM) begin
        lf_src_q <= w_byte_q[otc_pkg::BIT_LF_SRC];
        tune_q   <= w_byte_q[otc_pkg::TRIM_W-1:0];
        start_q  <= 1'b1;
      end
    end
  end

  // The enable is forced low in any oscillator mode that does not allow the PLL.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_en_q <= 1'b0;
    end else if (!pll_avail) begin
      pll_en_q <= 1'b0;
    end else if (wr_fire && w_lane_q
                 && aw_addr_q == otc_pkg::ADDR_TRIM) begin
      pll_en_q <= w_byte_q[otc_pkg::BIT_PLL_EN];
    end
  end

  // Configuration code and frequency select from the wider clock unit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cfg_q <= otc_pkg::OSC_CFG_RST;
      fsel_q    <= otc_pkg::FSEL_RST;
    end else if (wr_fire && w_lane_q && aw_addr_q == otc_pkg::ADDR_CFG) begin
      osc_cfg_q <= w_byte_q[otc_pkg::CFG_OSC_LSB +: 4];
      fsel_q    <= w_byte_q[otc_pkg::CFG_FSEL_LSB +: 3];
    end
  end

  // ****************************************************************
  // Settle timers
  // ****************************************************************
  assign fast_if.start  = start_q;
  assign fast_if.target = tune_q;
  assign slow_if.start  = start_q;
  assign slow_if.target = tune_q;

  otc_settle #(.CYCLES(FAST_CYC)) u_fast (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trim    (fast_if.unit)
  );

  otc_settle #(.CYCLES(SLOW_CYC)) u_slow (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trim    (slow_if.unit)
  );

  // ****************************************************************
  // Clock routing
  // ****************************************************************
  // Registered so that every routing output comes from a flip-flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_q <= 1'b0;
      lf_q  <= 1'b0;
      wdt_q <= 1'b1;
    end else begin
      pll_q <= pll_en_q && pll_avail && freq_ok;
      lf_q  <= lf_src_q;
      wdt_q <= 1'b1;
    end
  end

  // Linear estimate: the same step per code keeps the estimate honest.
  assign fast_khz = 16'(otc_pkg::NOMINAL_KHZ
                  + int'($signed(fast_if.applied)) * STEP_KHZ);

  // Postscaler taps halve per code; code 0 takes the low-freq source.
  always_comb begin
    if (fsel_q == otc_pkg::FSEL_LF) begin
      base_khz = lf_q ? (fast_khz >> otc_pkg::LF_DIV_SHIFT)
                      : 16'(otc_pkg::SLOW_RC_KHZ);
    end else begin
      base_khz = fast_khz >> (otc_pkg::FSEL_8M - fsel_q);
    end
    dev_khz = pll_q ? 16'(base_khz << otc_pkg::PLL_SHIFT)
                    : base_khz;
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (araddr == otc_pkg::ADDR_TRIM) begin
      rd_word[otc_pkg::BIT_LF_SRC]    = lf_src_q;
      // Gated so a stale enable never reads back in the cycle it clears.
      rd_word[otc_pkg::BIT_PLL_EN]    = pll_en_q && pll_avail;
      rd_word[otc_pkg::TRIM_W-1:0]    = tune_q;
    end else if (araddr == otc_pkg::ADDR_CFG) begin
      rd_word[otc_pkg::CFG_OSC_LSB +: 4]  = osc_cfg_q;
      rd_word[otc_pkg::CFG_FSEL_LSB +: 3] = fsel_q;
    end else if (araddr == otc_pkg::ADDR_STAT) begin
      rd_word[otc_pkg::STAT_PLL] = pll_q;
      rd_word[otc_pkg::STAT_LF]  = lf_q;
      rd_word[otc_pkg::STAT_WDT] = wdt_q;
      rd_word[otc_pkg::STAT_FAST_LSB +: otc_pkg::TRIM_W] = fast_if.applied;
      rd_word[otc_pkg::STAT_SLOW_LSB +: otc_pkg::TRIM_W] = slow_if.applied;
    end else if (araddr == otc_pkg::ADDR_FREQ) begin
      rd_word[15:0] = fast_khz;
      rd_word[otc_pkg::FREQ_DEV_LSB +: 16] = dev_khz;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One read at a time; data is sampled at the address handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= otc_pkg::RESP_OKAY;
    end else begin
      arready_q <= arvalid && !arready_q && !rvalid_q;
      if (arvalid && arready_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= rd_hit ? otc_pkg::RESP_OKAY : otc_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign awready      = awready_q;
  assign wready       = wready_q;
  assign bvalid       = bvalid_q;
  assign bresp        = bresp_q;
  assign arready      = arready_q;
  assign rvalid       = rvalid_q;
  assign rdata        = rdata_q;
  assign rresp        = rresp_q;
  assign fast_trim    = fast_if.applied;
  assign slow_trim    = slow_if.applied;
  assign pll_run      = pll_q;
  assign lf_from_fast = lf_q;
  assign wdt_on_slow  = wdt_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_gap_bit_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready_q && araddr == otc_pkg::ADDR_TRIM)
      |=> rdata_q[otc_pkg::BIT_RSVD] == 1'b0)
    else $error("Tuning bit 5 read as one.");

  a_pll_forced_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !pll_avail |=> !pll_en_q ##1 !pll_q)
    else $error("PLL enable not cleared in a non-internal mode.");

  a_pll_gating: assert property (@(posedge aclk) disable iff (!aresetn)
    pll_q == $past(pll_en_q && pll_avail && freq_ok))
    else $error("PLL state does not follow its gating.");

  a_pll_enable_write: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (wr_fire && w_lane_q && aw_addr_q == otc_pkg::ADDR_TRIM && pll_avail)
      |=> pll_en_q == $past(w_byte_q[otc_pkg::BIT_PLL_EN]))
    else $error("PLL enable not taken from tuning bit 6.");

  a_lf_source: assert property (@(posedge aclk) disable iff (!aresetn)
    lf_src_q |-> ##1 lf_q ##0 (fsel_q != otc_pkg::FSEL_LF
      || base_khz == (fast_khz >> otc_pkg::LF_DIV_SHIFT)))
    else $error("Low-frequency source not the divided fast osc.");

  a_wdt_slow: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> wdt_q)
    else $error("Watchdog moved off the slow RC.");

  a_trim_centre: assert property (@(posedge aclk) disable iff (!aresetn)
    fast_if.applied == otc_pkg::TRIM_RST
      |-> fast_khz == 16'(otc_pkg::NOMINAL_KHZ))
    else $error("Centre trim is not the nominal frequency.");

  a_uniform_step: assert property (@(posedge aclk) disable iff (!aresetn)
    int'(fast_khz) - otc_pkg::NOMINAL_KHZ
      == int'($signed(fast_if.applied)) * STEP_KHZ)
    else $error("Trim step is not uniform.");

  a_device_x4: assert property (@(posedge aclk) disable iff (!aresetn)
    pll_q |-> int'(dev_khz) == (int'(base_khz) << otc_pkg::PLL_SHIFT)
      && (fast_if.applied != otc_pkg::TRIM_RST
          || int'(dev_khz) <= otc_pkg::MAX_DEV_KHZ))
    else $error("PLL output is not four times its input.");

  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> bvalid_q)
    else $error("Write response not given next cycle.");

endmodule : otc_osc_tune

// *** otc_osc_tune_test.sv ***
// Self-checking bench for the oscillator tuning and PLL control block.
// Assumes otc_pkg and otc_trim_if are compiled before this file.
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("mismatch %s exp %h got %h", n, e, g); end end
module otc_osc_tune_test;
  // ****************************************************************
  // Stimulus signals
  // ****************************************************************
  logic        aclk    = 1'b0;   // Block clock, 4 ns period.
  logic        aresetn = 1'b0;   // Held low for two cycles.
  logic [7:0]  awaddr  = 8'h00;  // Write address.
  logic [7:0]  araddr  = 8'h00;  // Read address.
  logic [31:0] wdata   = 32'h0;  // Write data.
  logic [3:0]  wstrb   = 4'h1;   // Only lane 0 carries data.
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;     // Response codes.
  logic [31:0] rdata;            // Read data.
  logic [4:0]  fast_trim, slow_trim;
  logic        pll_run, lf_from_fast, wdt_on_slow;
  int          mismatches = 0;   // Failed comparisons.
  int          checks_done = 0;  // All comparisons.
  localparam logic [1:0] OK = otc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = otc_pkg::RESP_SLVERR;

  // Short settle counts keep the run brief; the 30-cycle waits below exceed both.
  otc_osc_tune #(.FAST_CYC(20), .SLOW_CYC(10), .STEP_KHZ(40)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .fast_trim(fast_trim), .slow_trim(slow_trim), .pll_run(pll_run),
    .lf_from_fast(lf_from_fast), .wdt_on_slow(wdt_on_slow));

  // The clock toggles every half period.
  always #2 aclk = ~aclk;

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  // Each channel is released at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", e, bresp)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    `CHK("rdata", d, rdata)
    `CHK("rresp", e, rresp)
  endtask : rd

  // Waits whole cycles, then lets the edge's updates land.
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : tick

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // A hung handshake ends here; the tests need under 2000 cycles.
  initial begin
    #20000;
    mismatches++;
    results();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h0, OK);
    rd(8'h08, 32'h4, OK);
    rd(8'h0c, 32'h03e8_1f40, OK);
    wr(8'h04, 32'h0, OK);
    wr(8'h00, 32'hff, OK);
    rd(8'h00, 32'h9f, OK);
    tick(5);
    `CHK("fast_trim", 5'h00, fast_trim)
    `CHK("slow_trim", 5'h00, slow_trim)
    tick(30);
    `CHK("fast_trim", 5'h1f, fast_trim)
    `CHK("slow_trim", 5'h1f, slow_trim)
    `CHK("lf_from_fast", 1'b1, lf_from_fast)
    `CHK("wdt_on_slow", 1'b1, wdt_on_slow)
    rd(8'h0c, 32'h001f_1f18, OK);
    wr(8'h00, 32'h0f, OK);
    tick(30);
    `CHK("fast_trim", 5'h0f, fast_trim)
    `CHK("lf_from_fast", 1'b0, lf_from_fast)
    rd(8'h0c, 32'h001f_2198, OK);
    wr(8'h00, 32'h10, OK);
    tick(30);
    `CHK("fast_trim", 5'h10, fast_trim)
    rd(8'h0c, 32'h001f_1cc0, OK);
    // Both internal modes, each with one of the two allowed taps.
    for (int i = 0; i < 2; i++) begin
      wr(8'h04, {25'h0, 3'(7 - i), 4'(8 + i)}, OK);
      wr(8'h00, 32'h40, OK);
      rd(8'h00, 32'h40, OK);
      tick(30);
      `CHK("pll_run", 1'b1, pll_run)
    end
    rd(8'h0c, 32'h3e80_1f40, OK);
    wr(8'h04, 32'h58, OK);
    tick(3);
    `CHK("pll_run", 1'b0, pll_run)
    wr(8'h04, 32'h70, OK);
    rd(8'h00, 32'h0, OK);
    `CHK("pll_run", 1'b0, pll_run)
    wr(8'h10, 32'h1, ERR);
    rd(8'h10, 32'h0, ERR);
    results();
  end
endmodule : otc_osc_tune_test

// *** otc_pkg.sv ***
// Constants shared by the oscillator tuning and PLL control block.
// Assumes a single 250 MHz clock and a 32-bit AXI4-Lite register bus.
package otc_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam int          ADDR_W         = 8;      // Decoded address bits.
  localparam logic [7:0]  ADDR_TRIM      = 8'h00;  // Oscillator tuning.
  localparam logic [7:0]  ADDR_CFG       = 8'h04;  // Clock configuration.
  localparam logic [7:0]  ADDR_STAT      = 8'h08;  // Block status.
  localparam logic [7:0]  ADDR_FREQ      = 8'h0c;  // Frequency estimate.
  localparam int          TRIM_W         = 5;      // Trim field width.
  localparam int          BIT_LF_SRC     = 7;      // Low-freq source select.
  localparam int          BIT_PLL_EN     = 6;      // PLL software enable.
  localparam int          BIT_RSVD       = 5;      // Unimplemented, reads 0.
  localparam int          CFG_OSC_LSB    = 0;      // Oscillator config code.
  localparam int          CFG_FSEL_LSB   = 4;      // Frequency select code.
  localparam int          STAT_PLL       = 0;      // PLL running.
  localparam int          STAT_LF        = 1;      // Low-freq from fast osc.
  localparam int          STAT_WDT       = 2;      // Watchdog on slow RC.
  localparam int          STAT_FAST_LSB  = 8;      // Applied fast trim.
  localparam int          STAT_SLOW_LSB  = 16;     // Applied slow trim.
  localparam int          FREQ_DEV_LSB   = 16;     // Device clock estimate.

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [4:0]  TRIM_RST       = 5'h00;  // Calibrated centre.
  localparam logic [3:0]  OSC_CFG_RST    = 4'h0;   // Config code at reset.
  localparam logic [2:0]  FSEL_RST       = 3'h4;   // 1 MHz at reset.
  localparam logic [3:0]  OSC_INT_IO2    = 4'h9;   // Internal osc mode.
  localparam logic [3:0]  OSC_INT_IO1    = 4'h8;   // Internal osc mode.
  localparam logic [2:0]  FSEL_8M        = 3'h7;   // Fast osc direct.
  localparam logic [2:0]  FSEL_4M        = 3'h6;   // First postscaler tap.
  localparam logic [2:0]  FSEL_LF        = 3'h0;   // Low-frequency tap.
  localparam logic [1:0]  RESP_OKAY      = 2'h0;   // AXI okay.
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;   // AXI slave error.

  // ****************************************************************
  // Frequencies and timing
  // ****************************************************************
  localparam int          NOMINAL_KHZ    = 8000;   // Fast osc at centre.
  localparam int          SLOW_RC_KHZ    = 31;     // Slow RC nominal.
  localparam int          MAX_DEV_KHZ    = 32000;  // Ceiling with the PLL.
  localparam int          PLL_SHIFT      = 2;      // Multiply by four.
  localparam int          LF_DIV_SHIFT   = 8;      // Divide by 256.
  localparam int          CLK_PERIOD_NS  = 4;      // 250 MHz clock.
  localparam int          FAST_SETTLE_NS = 1000000; // 1 ms settle.
  localparam int          SLOW_PERIOD_NS = 32000;  // Slow RC period.
  localparam int          SLOW_SETTLE_N  = 8;      // Slow RC edges.
  // Longest times, so both round down.
  localparam int          FAST_SETTLE_CYC = FAST_SETTLE_NS / CLK_PERIOD_NS;
  localparam int          SLOW_SETTLE_CYC =
    (SLOW_SETTLE_N * SLOW_PERIOD_NS) / CLK_PERIOD_NS;

  // Settle timer states, one-hot.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } otc_settle_t;

endpackage : otc_pkg

// *** otc_settle.sv ***
// Settle timer: moves an oscillator to a newly written trim no later
// than a fixed number of clock cycles after the write.
// Assumes target stays stable from the start pulse until it is applied.
`timescale 1ns/10ps
module otc_settle #(
  parameter int unsigned CYCLES = 8  // Longest settling time in cycles.
) (
  input  wire logic  aclk,     // Block clock.
  input  wire logic  aresetn,  // Synchronous reset, active low.
  otc_trim_if.unit   trim      // Trim request and applied value.
);

  // ****************************************************************
  // Countdown
  // ****************************************************************
  otc_pkg::otc_settle_t     state_q;  // Idle or waiting to apply.
  logic [31:0]              cnt_q;    // Cycles left before applying.
  logic [otc_pkg::TRIM_W-1:0] app_q;  // Trim in effect.

  // A new write restarts the wait, so the latest value always wins and
  // nothing flags completion to software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= otc_pkg::ST_IDLE;
      cnt_q   <= 32'h0000_0000;
    end else if (trim.start) begin
      state_q <= otc_pkg::ST_WAIT;
      cnt_q   <= 32'(CYCLES - 1);
    end else begin
      case (state_q)
        otc_pkg::ST_WAIT: begin
          if (cnt_q == 32'h0000_0000) begin
            state_q <= otc_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 32'h0000_0001;
          end
        end
        default: begin
          state_q <= otc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // The oscillator adopts the new trim at the end of the wait.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      app_q <= otc_pkg::TRIM_RST;
    end else if (state_q == otc_pkg::ST_WAIT && cnt_q == 32'h0000_0000
                 && !trim.start) begin
      app_q <= trim.target;
    end
  end

  assign trim.applied = app_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_settle_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == otc_pkg::ST_WAIT |-> cnt_q < 32'(CYCLES))
    else $error("Settle wait longer than its bound.");

  a_applied_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == otc_pkg::ST_IDLE |=> $stable(app_q) || $past(trim.start))
    else $error("Applied trim moved while idle.");

endmodule : otc_settle

// *** otc_trim_if.sv ***
// Interface carrying a trim update from the register logic to a settle unit.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface otc_trim_if;
  logic                        start;    // One-cycle new-trim pulse.
  logic [otc_pkg::TRIM_W-1:0]  target;   // Trim written by software.
  logic [otc_pkg::TRIM_W-1:0]  applied;  // Trim the oscillator runs at.

  modport ctrl (output start, output target, input applied);
  modport unit (input start, input target, output applied);
endinterface : otc_trim_if
